// [rtl/cpu_core_consts.vh]
/*
  constants for the cpu execution-control core: opcodes, field positions,
  special register numbers, vectors, address map and wait counts.
  assumes plain verilog-2005 and inclusion by bare name.
*/
`ifndef CPU_CORE_CONSTS_VH
`define CPU_CORE_CONSTS_VH

// ============================================================
// instruction word layout
`define OP_HI        31
`define OP_LO        26
`define RD_HI        25
`define RD_LO        22
`define RA_HI        21
`define RA_LO        18
`define RB_HI        17
`define RB_LO        14
`define FN_HI        13
`define FN_LO        11
`define SZ_HI        10
`define SZ_LO        9
`define IMM_HI       13
`define IMM_LO       0
`define IMM_W        14

// ============================================================
// opcodes
`define OPC_ALU      6'h00
`define OPC_ALUI     6'h01
`define OPC_LOAD     6'h02
`define OPC_STORE    6'h03
`define OPC_MFSR     6'h04
`define OPC_MTSR     6'h05
`define OPC_RFE      6'h06
`define OPC_DOZE     6'h07
`define OPC_TRAP     6'h08
`define OPC_CLKSEL   6'h09
`define OPC_JR       6'h0a

// alu functions
`define FN_ADD       3'h0
`define FN_SUB       3'h1
`define FN_AND       3'h2
`define FN_OR        3'h3
`define FN_XOR       3'h4
`define FN_SHIFT     3'h5
`define FN_CMP       3'h6
`define FN_MUL       3'h7

// operand sizes
`define SZ_BYTE      2'h0
`define SZ_HALF      2'h1
`define SZ_WORD      2'h2

// ============================================================
// special registers
`define SR_STATUS    4'h0
`define SR_EPC       4'h1
`define SR_ESR       4'h2
`define SR_IMASK     4'h3
`define ST_SUPER     0
`define ST_IE        1
`define ST_FLAG      2
`define ST_RESET     32'h0000_0001

// ============================================================
// vectors
`define VEC_RESET    32'h0000_0000
`define VEC_BUSERR   32'h0000_0008
`define VEC_ILLEGAL  32'h0000_0010
`define VEC_TRAP     32'h0000_0018
`define VEC_IRQ      32'h0000_0020

// ============================================================
// address map and wait counts
`define MEM_HI       31
`define MEM_LO       18
`define MEM_ROM      14'h0000
`define MEM_RAM      14'h0001
`define MEM_PERIPH   14'h0002
`define MEM_WAIT     2'h1
`define PER_WAIT     2'h2

// ============================================================
// clock rate selection: system clock 16 MHz, divider exponent 0..5
`define CLKSEL_W     3
`define CLKSEL_MAX   3'h5
`define CLKSEL_RST   3'h0
`define DIV_W        5

`endif

// [rtl/cpu_core_control.v]
/*
  execution-control side of a 32-bit load/store core: register file,
  three-cycle register ops (fetch, exec, retire), extra cycle for memory, privilege modes,
  one-cycle exception entry, doze and rate selection.
  assumes the memory bus answers a request with read data on the cycle
  after the wait count, and interrupt inputs arrive asynchronously.
*/
`timescale 1ns/1ps
`include "cpu_core_consts.vh"

// Function
// - fifteen 32-bit registers plus special registers
// - every register loadable and storable
// - alu ops register-register or register-immediate
// - register-only operations take one cycle; the core takes three cycles, fetch to retire
// - memory access adds one cycle
// - byte, halfword and word operands
// - hardware multiplier available
// - one linear 32-bit code/data space
// - peripheral registers live in that space
// - any register supplies memory address
// - user mode reaches only general registers
// - reset and interrupt enter supervisor mode
// - exception saves pc and status one cycle
// - pc gets vector, handler runs next
// - doze halts until interrupt arrives
// - core rate 0.5 to 16 mhz selectable
// - peripheral access takes three cycles
// - unmapped access raises bus error; code checks loads and stores only, not fetches
module cpu_core_control
(
  // clock and reset
  input  wire        clk_i,
  input  wire        resetn_i,
  // unified memory bus
  output reg  [31:0] mem_addr_o,
  output reg  [31:0] mem_wdata_o,
  output reg  [3:0]  mem_be_o,
  output reg         mem_req_o,
  output reg         mem_we_o,
  output reg         mem_fetch_o,
  input  wire [31:0] mem_rdata_i,
  // interrupt source, asynchronous level
  input  wire        irq_i,
  // core state
  output reg         supervisor_o,
  output reg         dozing_o,
  output reg  [2:0]  clk_sel_o,
  output wire        core_en_o
);

  localparam [1:0] ST_FETCH = 2'h0;
  localparam [1:0] ST_EXEC  = 2'h1;
  localparam [1:0] ST_MEM   = 2'h2;
  localparam [1:0] ST_DOZE  = 2'h3;

  // ============================================================
  // interrupt synchroniser
  reg irq_meta;
  reg irq_sync;
  always @(posedge clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      irq_meta <= 1'b0;
      irq_sync <= 1'b0;
    end
    else
    begin
      irq_meta <= irq_i;
      irq_sync <= irq_meta;
    end

  // ============================================================
  // core rate enable: 16 mhz system clock scaled by 2^sel
  reg  [`DIV_W-1:0] div_cnt;
  wire [`DIV_W-1:0] div_mask = (5'h01 << clk_sel_o) - 5'h01;
  assign core_en_o = ((div_cnt & div_mask) == 5'h00);
  always @(posedge clk_i or negedge resetn_i)
    if (!resetn_i)
      div_cnt <= 5'h00;
    else
      div_cnt <= div_cnt + 5'h01;

  // ============================================================
  // state
  reg [31:0] gpr [1:15];
  reg [31:0] pc;
  reg [31:0] status;
  reg [31:0] epc;
  reg [31:0] esr;
  reg [31:0] imask;
  reg [31:0] ir;
  reg [1:0]  state;
  reg [1:0]  wait_cnt;
  reg [3:0]  ld_rd;
  reg [1:0]  ld_sz;
  reg [1:0]  ld_off;

  wire [5:0]  opc  = ir[`OP_HI:`OP_LO];
  wire [3:0]  rd   = ir[`RD_HI:`RD_LO];
  wire [3:0]  ra   = ir[`RA_HI:`RA_LO];
  wire [3:0]  rb   = ir[`RB_HI:`RB_LO];
  wire [2:0]  fn   = ir[`FN_HI:`FN_LO];
  wire [1:0]  sz   = ir[`SZ_HI:`SZ_LO];
  wire [31:0] imm  = {{(32-`IMM_W){ir[`IMM_HI]}}, ir[`IMM_HI:`IMM_LO]};
  wire [31:0] va   = (ra == 4'h0) ? 32'h0000_0000 : gpr[ra];
  wire [31:0] vb   = (rb == 4'h0) ? 32'h0000_0000 : gpr[rb];
  wire [31:0] vd   = (rd == 4'h0) ? 32'h0000_0000 : gpr[rd];
  wire [31:0] opb  = (opc == `OPC_ALUI) ? imm : vb;
  wire [31:0] eadr = va + imm;
  wire        in_super = status[`ST_SUPER];
  wire [13:0] region = eadr[`MEM_HI:`MEM_LO];
  wire        mapped = (region == `MEM_ROM) || (region == `MEM_RAM) ||
                       (region == `MEM_PERIPH);
  wire        irq_take = irq_sync & status[`ST_IE] & imask[0];

  // ============================================================
  // alu with multiplier
  reg [31:0] alu;
  reg [63:0] prod;
  reg        flag;
  always @*
  begin
    prod = va * opb;
    flag = status[`ST_FLAG];
    alu  = 32'h0000_0000;
    case (fn)
      `FN_ADD:   alu = va + opb;
      `FN_SUB:   alu = va - opb;
      `FN_AND:   alu = va & opb;
      `FN_OR:    alu = va | opb;
      `FN_XOR:   alu = va ^ opb;
      // opb[5] picks left rotate, ignoring opb[6]; otherwise opb[6] picks right shift
      `FN_SHIFT:
        if (opb[5])
          alu = (va << opb[4:0]) | (va >> (6'h20 - {1'b0, opb[4:0]}));
        else if (opb[6])
          alu = va >> opb[4:0];
        else
          alu = va << opb[4:0];
      `FN_CMP:
      begin
        // opb[31] sign of immediate is not the mode; rd lsb picks signed
        flag = rd[0] ? ($signed(va) < $signed(opb)) : (va < opb);
        alu  = {31'h0000_0000, flag};
      end
      `FN_MUL:   alu = prod[31:0];
      default:   alu = 32'h0000_0000;
    endcase
  end

  // store lane placement for byte, halfword, word
  reg [31:0] st_data;
  reg [3:0]  st_be;
  always @*
  begin
    case (sz)
      `SZ_BYTE:
      begin
        st_data = {4{vd[7:0]}};
        st_be   = 4'h1 << eadr[1:0];
      end
      `SZ_HALF:
      begin
        st_data = {2{vd[15:0]}};
        st_be   = eadr[1] ? 4'hc : 4'h3;
      end
      default:
      begin
        st_data = vd;
        st_be   = 4'hf;
      end
    endcase
  end

  // load extraction, zero-extended
  reg [31:0] ld_val;
  always @*
  begin
    case (ld_sz)
      `SZ_BYTE: ld_val = {24'h000000,
                          mem_rdata_i[{ld_off, 3'h0} +: 8]};
      `SZ_HALF: ld_val = {16'h0000,
                          mem_rdata_i[{ld_off[1], 4'h0} +: 16]};
      default:  ld_val = mem_rdata_i;
    endcase
  end

  // ============================================================
  // sequencer
  integer i;
  always @(posedge clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      for (i = 1; i < 16; i = i + 1)
        gpr[i] <= 32'h0000_0000;
      pc           <= `VEC_RESET;
      status       <= `ST_RESET;
      epc          <= 32'h0000_0000;
      esr          <= 32'h0000_0000;
      imask        <= 32'h0000_0000;
      ir           <= 32'h0000_0000;
      state        <= ST_FETCH;
      wait_cnt     <= 2'h0;
      ld_rd        <= 4'h0;
      ld_sz        <= 2'h0;
      ld_off       <= 2'h0;
      mem_addr_o   <= 32'h0000_0000;
      mem_wdata_o  <= 32'h0000_0000;
      mem_be_o     <= 4'h0;
      mem_req_o    <= 1'b0;
      mem_we_o     <= 1'b0;
      mem_fetch_o  <= 1'b0;
      supervisor_o <= 1'b1;
      dozing_o     <= 1'b0;
      clk_sel_o    <= `CLKSEL_RST;
    end
    else if (core_en_o)
    begin
      mem_req_o   <= 1'b0;
      mem_we_o    <= 1'b0;
      mem_fetch_o <= 1'b0;
      case (state)
        ST_FETCH:
          if (irq_take)
          begin
            epc    <= pc;
            esr    <= status;
            status[`ST_SUPER] <= 1'b1;
            status[`ST_IE] <= 1'b0;
            supervisor_o <= 1'b1;
            pc     <= `VEC_IRQ;
          end
          else
          begin
            mem_addr_o  <= pc;
            mem_be_o    <= 4'hf;
            mem_req_o   <= 1'b1;
            mem_fetch_o <= 1'b1;
            state       <= ST_EXEC;
          end
        ST_EXEC:
        begin
          ir    <= mem_rdata_i;
          state <= ST_MEM;
          wait_cnt <= 2'h0;
        end
        ST_MEM:
        begin
          // decode and retire; register ops finish here in one cycle
          state <= ST_FETCH;
          pc    <= pc + 32'h4;
          case (opc)
            `OPC_ALU, `OPC_ALUI:
            begin
              if (rd != 4'h0)
                gpr[rd] <= alu;
              status[`ST_FLAG] <= flag;
            end
            `OPC_LOAD, `OPC_STORE:
              if (!mapped)
              begin
                epc    <= pc;
                esr    <= status;
                status[`ST_SUPER] <= 1'b1;
                status[`ST_IE]    <= 1'b0;
                supervisor_o      <= 1'b1;
                pc     <= `VEC_BUSERR;
              end
              else if (wait_cnt == 2'h0 && !mem_req_o)
              begin
                // issue access and hold the pc: one extra cycle, two for peripherals
                mem_addr_o  <= {eadr[31:2], 2'h0};
                mem_wdata_o <= st_data;
                mem_be_o    <= st_be;
                mem_req_o   <= 1'b1;
                mem_we_o    <= (opc == `OPC_STORE);
                ld_rd  <= rd;
                ld_sz  <= sz;
                ld_off <= eadr[1:0];
                wait_cnt <= (region == `MEM_PERIPH) ?
                            `PER_WAIT : `MEM_WAIT;
                state <= ST_MEM;
                pc    <= pc;
              end
              else if (wait_cnt > 2'h1)
              begin
                wait_cnt <= wait_cnt - 2'h1;
                state    <= ST_MEM;
                pc       <= pc;
              end
              else if (opc == `OPC_LOAD && ld_rd != 4'h0)
                gpr[ld_rd] <= ld_val;
            `OPC_MFSR:
              if (!in_super)
              begin
                epc <= pc;
                esr <= status;
                status[`ST_SUPER] <= 1'b1;
                status[`ST_IE]    <= 1'b0;
                supervisor_o      <= 1'b1;
                pc <= `VEC_ILLEGAL;
              end
              else if (rd != 4'h0)
                case (ra)
                  `SR_STATUS: gpr[rd] <= status;
                  `SR_EPC:    gpr[rd] <= epc;
                  `SR_ESR:    gpr[rd] <= esr;
                  default:    gpr[rd] <= imask;
                endcase
            `OPC_MTSR:
              if (in_super)
                case (rd)
                  `SR_STATUS:
                  begin
                    status       <= va;
                    supervisor_o <= va[`ST_SUPER];
                  end
                  `SR_EPC:    epc   <= va;
                  `SR_ESR:    esr   <= va;
                  default:    imask <= va;
                endcase
            `OPC_RFE:
              if (in_super)
              begin
                pc           <= epc;
                status       <= esr;
                supervisor_o <= esr[`ST_SUPER];
              end
            `OPC_DOZE:
            begin
              dozing_o <= 1'b1;
              state    <= ST_DOZE;
            end
            `OPC_TRAP:
            begin
              epc <= pc + 32'h4;
              esr <= status;
              status[`ST_SUPER] <= 1'b1;
              status[`ST_IE]    <= 1'b0;
              supervisor_o      <= 1'b1;
              pc <= `VEC_TRAP;
            end
            `OPC_CLKSEL:
              if (in_super && va[2:0] <= `CLKSEL_MAX)
                clk_sel_o <= va[2:0];
            `OPC_JR:
              pc <= va;
            default:
            begin
              epc <= pc;
              esr <= status;
              status[`ST_SUPER] <= 1'b1;
              status[`ST_IE]    <= 1'b0;
              supervisor_o      <= 1'b1;
              pc <= `VEC_ILLEGAL;
            end
          endcase
        end
        ST_DOZE:
          // wake on any pending request, even if masked by ie
          if (irq_sync)
          begin
            dozing_o <= 1'b0;
            state    <= ST_FETCH;
          end
        default:
          state <= ST_FETCH;
      endcase
    end

endmodule

// [tb/mem_model.sv]
/*
  memory bus partner: rom, ram and peripheral regions, 1k words each.
  assumes core_en_i marks the core steps and the core holds its request.
*/
`timescale 1ns/1ps
module mem_model
(
  // bus from the core
  input  wire logic        clk_i,
  input  wire logic        core_en_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  be_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  // answer
  output logic      [31:0] rdata_o
);
  logic [31:0] m [0:4095];
  logic [11:0] idx = 12'h000;
  logic [1:0]  cnt = 2'h0;
  logic [31:0] last = 32'h0000_0000;

  initial
  begin
    foreach (m[i]) m[i] = 32'h0000_0000;
  end

  // ==========================================================
  // access timing and writes
  always @(posedge clk_i)
  begin
    last <= rdata_o;
    if (core_en_i)
    begin
      if (req_i)
      begin
        idx <= {addr_i[19:18], addr_i[11:2]};
        cnt <= (addr_i[19:18] == 2'h2) ? 2'h1 : 2'h0;
      end
      else if (cnt != 2'h0)
        cnt <= cnt - 2'h1;
      if (req_i && we_i)
        for (int b = 0; b < 4; b++)
          if (be_i[b])
            m[{addr_i[19:18], addr_i[11:2]}][8*b+:8] <= wdata_i[8*b+:8];
    end
  end

  // rom and ram answer while the request stands, peripherals a step later;
  // outside the answer step the data lines toggle, never hold
  assign rdata_o = (req_i && addr_i[19:18] != 2'h2) ?
                   m[{addr_i[19:18], addr_i[11:2]}] :
                   (cnt == 2'h1) ? m[idx] : ~last;
endmodule

// [tb/cpu_core_control_chk.sv]
/*
  concurrent checks on the ports of the core control block.
  assumes one clock domain and the async active-low reset.
*/
`timescale 1ns/1ps
module cpu_core_control_chk
(
  // watched ports
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic [31:0] mem_addr_o,
  input wire logic [3:0]  mem_be_o,
  input wire logic        mem_req_o,
  input wire logic        mem_we_o,
  input wire logic        mem_fetch_o,
  input wire logic        irq_i,
  input wire logic        supervisor_o,
  input wire logic        dozing_o,
  input wire logic [2:0]  clk_sel_o,
  input wire logic        core_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  a_reset_state: assert property ($rose(resetn_i) |-> supervisor_o &&
    !dozing_o && !mem_req_o && clk_sel_o == 3'h0) else $error("bad reset state");
  a_req_one_step: assert property (mem_req_o && core_en_o |=> !mem_req_o)
    else $error("request stands too long");
  a_reg_op: assert property (clk_sel_o == 3'h0 && mem_req_o && mem_fetch_o
    |=> !mem_req_o ##1 !mem_fetch_o) else $error("fetch too soon");
  a_mem_gap: assert property (clk_sel_o == 3'h0 && mem_req_o && !mem_fetch_o
    && mem_addr_o[31:18] <= 14'h0001 |=> !mem_req_o ##1 (mem_req_o && mem_fetch_o))
    else $error("memory op step count wrong");
  a_per_gap: assert property (clk_sel_o == 3'h0 && mem_req_o && !mem_fetch_o
    && mem_addr_o[31:18] == 14'h0002 |=> !mem_req_o [*2] ##1 mem_fetch_o)
    else $error("peripheral op step count wrong");
  a_mapped_only: assert property (mem_req_o |-> mem_addr_o[31:18] <= 14'h0002)
    else $error("request to unmapped address");
  a_lane_set: assert property (mem_req_o && mem_we_o |-> mem_be_o inside
    {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf}) else $error("bad byte lanes");
  a_doze_quiet: assert property (dozing_o |-> !mem_req_o)
    else $error("request while dozing");
  a_doze_wake: assert property (clk_sel_o == 3'h0 && dozing_o && irq_i
    |-> ##[1:6] !dozing_o) else $error("no wake on interrupt");
  a_full_rate: assert property (clk_sel_o == 3'h0 |-> core_en_o)
    else $error("enable missing at full rate");
  a_quarter_rate: assert property (clk_sel_o == 3'h2 && core_en_o &&
    $past(clk_sel_o, 4) == 3'h2 |=> !core_en_o [*3] ##1 core_en_o)
    else $error("quarter rate enable wrong");
endmodule

bind cpu_core_control cpu_core_control_chk u_chk
(
  .clk_i        (clk_i),
  .resetn_i     (resetn_i),
  .mem_addr_o   (mem_addr_o),
  .mem_be_o     (mem_be_o),
  .mem_req_o    (mem_req_o),
  .mem_we_o     (mem_we_o),
  .mem_fetch_o  (mem_fetch_o),
  .irq_i        (irq_i),
  .supervisor_o (supervisor_o),
  .dozing_o     (dozing_o),
  .clk_sel_o    (clk_sel_o),
  .core_en_o    (core_en_o)
);

// [tb/tb.sv]
/*
  self-checking bench: small programs in the memory model, fetch trace.
  assumes the core starts at address 0 after reset, at full rate.
*/
`timescale 1ns/1ps
`include "cpu_core_consts.vh"
module tb;
  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        irq_i = 1'b0;
  logic [31:0] mem_addr_o, mem_wdata_o, mem_rdata_i;
  logic [3:0]  mem_be_o;
  logic        mem_req_o, mem_we_o, mem_fetch_o;
  logic        supervisor_o, dozing_o, core_en_o;
  logic [2:0]  clk_sel_o;
  int          n_errors = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          fc[$];
  logic [31:0] fa[$];
  logic        fs[$];

  cpu_core_control DUT (.clk_i(clk_i), .resetn_i(resetn_i),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_be_o(mem_be_o),
    .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_fetch_o(mem_fetch_o),
    .mem_rdata_i(mem_rdata_i), .irq_i(irq_i), .supervisor_o(supervisor_o),
    .dozing_o(dozing_o), .clk_sel_o(clk_sel_o), .core_en_o(core_en_o));
  mem_model mm (.clk_i(clk_i), .core_en_i(core_en_o), .addr_i(mem_addr_o),
    .wdata_i(mem_wdata_o), .be_i(mem_be_o), .req_i(mem_req_o),
    .we_i(mem_we_o), .rdata_o(mem_rdata_i));

  always #25 clk_i = ~clk_i;

  // ==========================================================
  // fetch trace and hang guard
  always @(posedge clk_i)
  begin
    cyc++;
    if (mem_req_o === 1'b1 && mem_fetch_o === 1'b1 && core_en_o === 1'b1)
    begin
      fc.push_back(cyc);
      fa.push_back(mem_addr_o);
      fs.push_back(supervisor_o);
    end
    if (cyc > 5000)
    begin
      n_errors++;
      end_of_test();
    end
  end

  task end_of_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  function logic [31:0] f(logic [5:0] op, logic [3:0] rd, logic [3:0] ra,
                          logic [17:0] v);
    return {op, rd, ra, v};
  endfunction

  task rst;
    @(negedge clk_i);
    resetn_i = 1'b0;
    irq_i = 1'b0;
    repeat (20) @(negedge clk_i);
    chk(supervisor_o, 1); chk(mem_req_o, 0); chk(clk_sel_o, 0);
    fc.delete();
    fa.delete();
    fs.delete();
    resetn_i = 1'b1;
  endtask

  // waits for n fetches, bounded
  task run(input int n);
    for (int k = 0; k < 600 && fa.size() < n; k++) @(negedge clk_i);
    chk(fa.size() >= n, 1);
  endtask

  // ==========================================================
  // scenarios
  task t_buserr;
    mm.m[0] = f(`OPC_LOAD, 4'h1, 4'h0, 18'h03c00);
    rst();
    run(2);
    chk(fa[1], `VEC_BUSERR); chk(fs[1], 1);
    $display("bus error test done");
  endtask

  task t_ops;
    int d[9] = '{3, 3, 3, 4, 4, 4, 5, 4, 4};
    mm.m[0] = f(`OPC_ALUI, 4'h1, 4'h0, 18'h00005);
    mm.m[1] = f(`OPC_ALUI, 4'h2, 4'h0, 18'h00003);
    mm.m[2] = f(`OPC_ALU, 4'h3, 4'h1, {4'h2, `FN_MUL, 11'h000});
    mm.m[3] = f(`OPC_LOAD, 4'h4, 4'h0, 18'h00400);
    mm.m[4] = f(`OPC_STORE, 4'h3, 4'h4, 18'h00400);
    mm.m[5] = f(`OPC_LOAD, 4'h7, 4'h0, 18'h00404);
    mm.m[6] = f(`OPC_LOAD, 4'h5, 4'h7, 18'h00400);
    mm.m[7] = f(`OPC_STORE, 4'h5, 4'h4, 18'h00404);
    mm.m[8] = f(`OPC_STORE, 4'h1, 4'h4, 18'h00009);
    mm.m[9] = f(`OPC_DOZE, 4'h0, 4'h0, 18'h00000);
    mm.m[10] = 32'h0000_0000;
    mm.m[12'h100] = 32'h0004_0000;
    mm.m[12'h101] = 32'h0008_0000;
    mm.m[12'h900] = 32'ha5a5_0001;
    rst();
    run(10);
    repeat (10) @(negedge clk_i);
    chk(dozing_o, 1); chk(fa.size(), 10);
    irq_i = 1'b1;
    run(11);
    irq_i = 1'b0;
    for (int i = 0; i < 11; i++) chk(fa[i], 4 * i);
    for (int i = 0; i < 9; i++) chk(fc[i+1] - fc[i], d[i]);
    chk(mm.m[12'h500], 32'h0000_000f);
    chk(mm.m[12'h501], 32'ha5a5_0001);
    chk(mm.m[12'h402], 32'h0000_0500);
    $display("operations test done");
  endtask

  task t_priv;
    // rate comes from a register; 7 is out of range and has the mode bit
    mm.m[0] = f(`OPC_ALUI, 4'h3, 4'h0, 18'h00002);
    mm.m[1] = f(`OPC_CLKSEL, 4'h0, 4'h3, 18'h00000);
    mm.m[2] = f(`OPC_ALUI, 4'h2, 4'h0, 18'h00007);
    mm.m[3] = f(`OPC_CLKSEL, 4'h0, 4'h2, 18'h00000);
    mm.m[4] = f(`OPC_MTSR, `SR_STATUS, 4'h0, 18'h00000);
    mm.m[5] = f(`OPC_MTSR, `SR_STATUS, 4'h2, 18'h00000);
    mm.m[6] = f(`OPC_RFE, 4'h0, 4'h0, 18'h00000);
    mm.m[7] = f(`OPC_TRAP, 4'h0, 4'h0, 18'h00000);
    mm.m[8] = 32'h0000_0000;
    rst();
    run(10);
    chk(clk_sel_o, 3'h2);
    chk(fa[6], 32'h18); chk(fs[6], 0);
    chk(fa[7], 32'h1c);
    chk(fa[8], `VEC_TRAP); chk(fs[8], 1);
    chk(fa[9], 32'h20); chk(fs[9], 0);
    $display("privilege test done");
  endtask

  task t_irq;
    // user mode with interrupts on, so the entry must raise supervisor
    mm.m[0] = f(`OPC_ALUI, 4'h1, 4'h0, 18'h00003);
    mm.m[1] = f(`OPC_MTSR, `SR_IMASK, 4'h1, 18'h00000);
    mm.m[2] = f(`OPC_ALUI, 4'h1, 4'h0, 18'h00002);
    mm.m[3] = f(`OPC_MTSR, `SR_STATUS, 4'h1, 18'h00000);
    mm.m[4] = f(`OPC_DOZE, 4'h0, 4'h0, 18'h00000);
    rst();
    run(5);
    repeat (10) @(negedge clk_i);
    chk(dozing_o, 1);
    irq_i = 1'b1;
    run(6);
    irq_i = 1'b0;
    chk(fa[5], `VEC_IRQ);
    chk(fs[4], 0); chk(fs[5], 1);
    $display("interrupt test done");
  endtask

  initial
  begin
    t_buserr();
    t_ops();
    t_priv();
    t_irq();
    end_of_test();
  end
endmodule
